// ---- pcr_pkg.sv ----
// Purpose: constants for the pll counter reset / charge pump hi-z control block
// Assumes: avalon-mm word addressing in bytes, 32-bit data
// Notes:   one clock domain at 100 MHz

package pcr_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] PCR_CTRL_OFS    = 4'h0;
   localparam logic [3:0] PCR_STAT_OFS    = 4'h4;
   localparam logic [3:0] PCR_PWR_OFS     = 4'h8;

   // ****************************************
   // control field positions
   // ****************************************
   localparam int PCR_MAIN_CP_HIZ_BIT     = 0;
   localparam int PCR_AUX_CP_HIZ_BIT      = 1;
   localparam int PCR_MAIN_CNT_RST_BIT    = 2;
   localparam int PCR_AUX_CNT_RST_BIT     = 3;
   localparam int PCR_PWR_UP_BIT          = 0;

   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [3:0] PCR_CTRL_RST    = 4'h0;
   localparam logic       PCR_PWR_RST     = 1'b0;
   localparam int         PCR_PU_RST_NS   = 100;
   localparam int         PCR_CLK_NS      = 10;
   localparam logic [3:0] PCR_PU_RST_CYC  = 4'((PCR_PU_RST_NS + PCR_CLK_NS - 1) / PCR_CLK_NS);
endpackage

// ---- pcr_pu_timer.sv ----
// Purpose: stretch a power-up event into a counter reset pulse
// Assumes: start is a one-cycle pulse
// Notes:   a start during a running pulse restarts it

`timescale 1ns/10ps
module pcr_pu_timer
   import pcr_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   input  wire logic start_i,
   output logic      busy_o
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (start_i) begin
         cnt_nxt = PCR_PU_RST_CYC;
      end else if (cnt_r != 4'h0) begin
         cnt_nxt = cnt_r - 4'h1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy_o = (cnt_r != 4'h0);
endmodule

// ---- pcr_ctrl.sv ----
// Purpose: per-pll counter reset and charge pump hi-z control, avalon-mm slave
// Assumes: chip enable pin synchronous to clk_sys_i
// Notes:   waitrequest low one cycle after request; outputs registered
//
// Behaviour
// RULE1: aux reset bit resets aux counters, hi-z pump
// RULE2: aux reset bit defaults zero, normal run
// RULE3: main reset bit resets main counters, hi-z pump
// RULE4: main reset bit defaults zero
// RULE5: power-up by software or pin resets counters
// RULE6: main disable bit hi-z pump, counters run
// RULE7: main disable bit defaults zero
// RULE8: aux disable bit hi-z pump, counters run
// RULE9: aux disable bit defaults zero
// RULE10: hi-z on either bit; reset only on reset

`timescale 1ns/10ps
module pcr_ctrl
   import pcr_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        chip_en_i,
   output logic             main_counter_rst_o,
   output logic             aux_counter_rst_o,
   output logic             main_cp_hiz_o,
   output logic             aux_cp_hiz_o,
   output logic             powered_o
);
   // ****************************************
   // state
   // ****************************************
   logic [3:0]  ctrl_r;
   logic [3:0]  ctrl_nxt;
   logic        sw_pu_r;
   logic        sw_pu_nxt;
   logic        ce_r;
   logic        pwr_r;
   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] rd_r;
   logic [31:0] rd_nxt;
   logic        pu_busy;
   logic        pu_start;
   logic        pwr_now;
   logic        main_rst_nxt;
   logic        aux_rst_nxt;
   logic        main_hiz_nxt;
   logic        aux_hiz_nxt;
   logic        req;

   assign req      = (avs_read_i | avs_write_i) & ~ack_r;
   // power is on only while both software and the pin ask for it
   assign pwr_now  = sw_pu_r & ce_r;
   assign pu_start = pwr_now & ~pwr_r; // RULE5

   pcr_pu_timer u_pu_timer (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (pu_start),
      .busy_o    (pu_busy)
   );

   // ****************************************
   // register bus
   // ****************************************
   always_comb begin
      ctrl_nxt  = ctrl_r;
      sw_pu_nxt = sw_pu_r;
      ack_nxt   = req;
      rd_nxt    = rd_r;
      // write lands at the answer edge, the one the master sees as done
      if (ack_r && avs_write_i) begin
         unique case (avs_address_i)
            PCR_CTRL_OFS: ctrl_nxt  = avs_writedata_i[3:0];
            PCR_PWR_OFS:  sw_pu_nxt = avs_writedata_i[PCR_PWR_UP_BIT];
            default:      ctrl_nxt  = ctrl_r;
         endcase
      end
      if (req && avs_read_i) begin
         unique case (avs_address_i)
            PCR_CTRL_OFS: rd_nxt = {28'h0, ctrl_r};
            PCR_STAT_OFS: rd_nxt = {27'h0, powered_o, aux_cp_hiz_o, main_cp_hiz_o,
                                    aux_counter_rst_o, main_counter_rst_o};
            PCR_PWR_OFS:  rd_nxt = {31'h0, sw_pu_r};
            default:      rd_nxt = 32'h0;
         endcase
      end
   end

   // ****************************************
   // pll control outputs
   // ****************************************
   always_comb begin
      // counters only reset by reset bits or the power-up pulse, never by hi-z bits
      main_rst_nxt = ctrl_r[PCR_MAIN_CNT_RST_BIT] | pu_busy;   // RULE3 RULE5 RULE10
      aux_rst_nxt  = ctrl_r[PCR_AUX_CNT_RST_BIT] | pu_busy;    // RULE1 RULE5 RULE10
      main_hiz_nxt = main_rst_nxt | ctrl_r[PCR_MAIN_CP_HIZ_BIT]; // RULE3 RULE6 RULE10
      aux_hiz_nxt  = aux_rst_nxt | ctrl_r[PCR_AUX_CP_HIZ_BIT];   // RULE1 RULE8 RULE10
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_r             <= PCR_CTRL_RST; // RULE2 RULE4 RULE7 RULE9
         sw_pu_r            <= PCR_PWR_RST;
         ce_r               <= 1'b0;
         pwr_r              <= 1'b0;
         ack_r              <= 1'b0;
         rd_r               <= 32'h0;
         avs_waitrequest_o  <= 1'b1;
         main_counter_rst_o <= 1'b0;
         aux_counter_rst_o  <= 1'b0;
         main_cp_hiz_o      <= 1'b0;
         aux_cp_hiz_o       <= 1'b0;
         powered_o          <= 1'b0;
      end else begin
         ctrl_r             <= ctrl_nxt;
         sw_pu_r            <= sw_pu_nxt;
         ce_r               <= chip_en_i;
         pwr_r              <= pwr_now;
         ack_r              <= ack_nxt;
         rd_r               <= rd_nxt;
         avs_waitrequest_o  <= ~ack_nxt;
         main_counter_rst_o <= main_rst_nxt;
         aux_counter_rst_o  <= aux_rst_nxt;
         main_cp_hiz_o      <= main_hiz_nxt;
         aux_cp_hiz_o       <= aux_hiz_nxt;
         powered_o          <= pwr_now;
      end
   end

   assign avs_readdata_o    = rd_r;

   // ****************************************
   // checks
   // ****************************************
   property p_aux_rst;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      ctrl_r[PCR_AUX_CNT_RST_BIT] |=> aux_counter_rst_o && aux_cp_hiz_o;
   endproperty
   a_aux_rst: assert property (p_aux_rst) else $error("aux reset not applied"); // RULE1

   property p_aux_norm;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ctrl_r == 4'h0 && !pu_busy) |=> !aux_counter_rst_o && !aux_cp_hiz_o;
   endproperty
   a_aux_norm: assert property (p_aux_norm) else $error("aux not normal"); // RULE2

   property p_main_rst;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      ctrl_r[PCR_MAIN_CNT_RST_BIT] |=> main_counter_rst_o && main_cp_hiz_o;
   endproperty
   a_main_rst: assert property (p_main_rst) else $error("main reset not applied"); // RULE3

   property p_main_norm;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ctrl_r == 4'h0 && !pu_busy) |=> !main_counter_rst_o && !main_cp_hiz_o;
   endproperty
   a_main_norm: assert property (p_main_norm) else $error("main not normal"); // RULE4

   sequence s_pu_edge;
      pwr_now && !pwr_r;
   endsequence
   property p_pu;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_pu_edge |=> ##1 main_counter_rst_o && aux_counter_rst_o;
   endproperty
   a_pu: assert property (p_pu) else $error("no counter reset at power-up"); // RULE5

   property p_main_tri;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ctrl_r[PCR_MAIN_CP_HIZ_BIT] && !ctrl_r[PCR_MAIN_CNT_RST_BIT] && !pu_busy)
         |=> main_cp_hiz_o && !main_counter_rst_o;
   endproperty
   a_main_tri: assert property (p_main_tri) else $error("main hi-z wrong"); // RULE6

   property p_aux_tri;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ctrl_r[PCR_AUX_CP_HIZ_BIT] && !ctrl_r[PCR_AUX_CNT_RST_BIT] && !pu_busy)
         |=> aux_cp_hiz_o && !aux_counter_rst_o;
   endproperty
   a_aux_tri: assert property (p_aux_tri) else $error("aux hi-z wrong"); // RULE8

   property p_rst_hiz;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (main_counter_rst_o |-> main_cp_hiz_o) and (aux_counter_rst_o |-> aux_cp_hiz_o);
   endproperty
   a_rst_hiz: assert property (p_rst_hiz) else $error("reset without hi-z"); // RULE10

   property p_dflt;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |-> ctrl_r == PCR_CTRL_RST;
   endproperty
   a_dflt: assert property (p_dflt) else $error("control default wrong"); // RULE7 RULE9

   property p_main_cnt_only;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!ctrl_r[PCR_MAIN_CNT_RST_BIT] && !pu_busy) |=> !main_counter_rst_o;
   endproperty
   a_main_cnt_only: assert property (p_main_cnt_only) else $error("main reset stray"); // RULE10

   property p_aux_cnt_only;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!ctrl_r[PCR_AUX_CNT_RST_BIT] && !pu_busy) |=> !aux_counter_rst_o;
   endproperty
   a_aux_cnt_only: assert property (p_aux_cnt_only) else $error("aux reset stray"); // RULE10

   property p_pu_hiz;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      pu_busy |=> main_cp_hiz_o && aux_cp_hiz_o && main_counter_rst_o && aux_counter_rst_o;
   endproperty
   a_pu_hiz: assert property (p_pu_hiz) else $error("power-up reset dropped"); // RULE5

   // one-cycle answer, so a held request is never taken twice
   property p_wait_one;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
endmodule

// ---- pcr_host.sv ----
// Purpose: avalon-mm host model writing pll control words
// Assumes: slave answers through waitrequest, latency not assumed
// Notes:   signals change only just after a rising edge
`timescale 1ns/10ps
module pcr_host (
   input  wire logic        clk_i,
   input  wire logic        waitrequest_i,
   output logic [3:0]       address_o,
   output logic             read_o,
   output logic             write_o,
   output logic [31:0]      writedata_o
);
   initial begin
      address_o   = 4'h0;
      read_o      = 1'b0;
      write_o     = 1'b0;
      writedata_o = 32'h0;
   end

   // holds the request until waitrequest is seen low at an edge
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      address_o   <= a;
      writedata_o <= d;
      write_o     <= wr;
      read_o      <= ~wr;
      do @(posedge clk_i); while (waitrequest_i !== 1'b0);
      write_o     <= 1'b0;
      read_o      <= 1'b0;
      // released data inverted so stale values never look valid
      writedata_o <= ~d;
   endtask
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for the counter reset / hi-z control block
// Assumes: host model drives the register bus
// Notes:   expected results queued by the driver, checked by a monitor
`timescale 1ns/10ps
module testbench
   import pcr_pkg::*;
;
   logic        clk_sys_i;
   logic        sys_rst_i;
   logic        chip_en_i;
   logic [3:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        main_counter_rst_o;
   logic        aux_counter_rst_o;
   logic        main_cp_hiz_o;
   logic        aux_cp_hiz_o;
   logic        powered_o;
   logic [36:0] exp_q[$];
   logic [36:0] note;
   logic [4:0]  st;
   logic [3:0]  c;
   logic [31:0] r;
   int          errors;
   int          n_tests;

   pcr_ctrl dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .chip_en_i(chip_en_i), .main_counter_rst_o(main_counter_rst_o),
      .aux_counter_rst_o(aux_counter_rst_o), .main_cp_hiz_o(main_cp_hiz_o),
      .aux_cp_hiz_o(aux_cp_hiz_o), .powered_o(powered_o));
   pcr_host host (.clk_i(clk_sys_i), .waitrequest_i(avs_waitrequest_o),
      .address_o(avs_address_i), .read_o(avs_read_i), .write_o(avs_write_i),
      .writedata_o(avs_writedata_i));

   // ****************************************
   // checking
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back({st, e});
      host.xfer(1'b0, a, 32'h0);
   endtask

   // counts edges with all four outputs forced by the power-up pulse
   task automatic pulse();
      int n;
      n = 0;
      repeat (30) begin
         @(posedge clk_sys_i);
         if ((main_counter_rst_o & aux_counter_rst_o & main_cp_hiz_o & aux_cp_hiz_o) === 1'b1) n++;
      end
      chk(32'(n), 32'(PCR_PU_RST_CYC));
   endtask

   // outputs are level signals, so they are compared at every read answer
   always @(posedge clk_sys_i) begin
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
         note = exp_q.pop_front();
         chk(avs_readdata_o, note[31:0]);
         chk({27'h0, powered_o, aux_cp_hiz_o, main_cp_hiz_o, aux_counter_rst_o,
            main_counter_rst_o}, {27'h0, note[36:32]});
      end
   end

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      #50000;
      errors++;
      results();
   end

   initial begin
      sys_rst_i = 1'b1;
      chip_en_i = 1'b0;
      st = 5'h0;
      errors = 0;
      n_tests = 0;
      r = $urandom(32'h9fe2);
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      rd(PCR_CTRL_OFS, 32'h0);
      rd(PCR_STAT_OFS, 32'h0);
      $display("test defaults done");
      for (int i = 0; i < 16; i++) begin
         c = 4'(i) ^ r[3:0];
         host.xfer(1'b1, PCR_CTRL_OFS, {28'h0, c});
         repeat (3) @(posedge clk_sys_i);
         st = {1'b0, c[3] | c[1], c[2] | c[0], c[3], c[2]};
         rd(PCR_STAT_OFS, {27'h0, st});
         rd(PCR_CTRL_OFS, {28'h0, c});
      end
      $display("test control codes done");
      host.xfer(1'b1, PCR_CTRL_OFS, 32'h0);
      repeat (3) @(posedge clk_sys_i);
      st = 5'h0;
      host.xfer(1'b1, 4'hc, $urandom);
      rd(4'hc, 32'h0);
      rd(PCR_CTRL_OFS, 32'h0);
      $display("test unmapped done");
      chip_en_i <= 1'b1;
      host.xfer(1'b1, PCR_PWR_OFS, 32'h1);
      pulse();
      st = 5'h10;
      rd(PCR_STAT_OFS, 32'h10);
      rd(PCR_PWR_OFS, 32'h1);
      chip_en_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      st = 5'h0;
      rd(PCR_STAT_OFS, 32'h0);
      chip_en_i <= 1'b1;
      pulse();
      st = 5'h10;
      rd(PCR_STAT_OFS, 32'h10);
      $display("test power-up done");
      host.xfer(1'b1, PCR_CTRL_OFS, 32'hf);
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      st = 5'h0;
      rd(PCR_CTRL_OFS, 32'h0);
      rd(PCR_STAT_OFS, 32'h0);
      rd(PCR_PWR_OFS, 32'h0);
      $display("test mid-run reset done");
      results();
   end
endmodule
